// file: logic/ucr_pkg.sv
// Package with offsets, reset values, field positions and carrier types.
package ucr_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int FLAG_N = 9;
  localparam int EPID_W = 4;

  // ==========================================================================
  // Byte offsets from the register base
  // ==========================================================================
  localparam logic [11:0] OFS_EP_CTL = 12'h000;
  localparam logic [11:0] OFS_PKT_MEM = 12'h400;
  localparam logic [11:0] OFS_DEV_CTL = 12'h840;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h844;
  localparam logic [11:0] OFS_DESC_BASE = 12'h850;

  // ==========================================================================
  // Values after reset and access masks
  // ==========================================================================
  localparam logic [15:0] RST_DEV_CTL = 16'h0003;
  localparam logic [15:0] RST_EP_CTL = 16'h0000;
  localparam logic [15:0] RST_DESC_BASE = 16'h0000;
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  localparam logic [15:0] DEV_CTL_RW_MASK = 16'hff9f;
  localparam logic [15:0] DESC_BASE_MASK = 16'hfff8;
  localparam logic [15:0] EP_TOGGLE_MASK = 16'hf000;
  localparam logic [15:0] UPPER_ZERO = 16'h0000;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int FLAG_LSB = 7;
  localparam int EPID_LSB = 0;
  localparam int EP_HW_TOGGLE_BIT = 12;
  localparam int CTL_RESUME = 4;
  localparam int CTL_FSLEEP = 3;
  localparam int CTL_LOWPWR = 2;
  localparam int CTL_PDOWN = 1;
  localparam int CTL_FREINIT = 0;
  localparam int DESC_IDX_SHIFT = 3;
  localparam int DESC_SEL_SHIFT = 1;
  localparam int PKT_WORD_SHIFT = 2;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  // Ordered so that the struct lines up with status bits 15 down to 7.
  typedef struct packed {
    logic transfer_done_flag;
    logic dma_overflow_flag;
    logic fault_flag;
    logic wake_flag;
    logic sleep_request_flag;
    logic bus_reinit_flag;
    logic frame_start_flag;
    logic expected_frame_flag;
    logic zero_packet_flag;
  } ucr_evt_t;

  typedef struct packed {
    logic resume_signal;
    logic force_sleep_entry;
    logic transceiver_low_power;
    logic power_down_ctl;
    logic force_bus_reinit;
  } ucr_ctl_t;

  typedef struct packed {
    logic rd;
    logic [3:0] idx;
    logic [1:0] sel;
  } ucr_desc_req_t;

endpackage

// file: logic/ucr_flags.sv
// Sticky event flags cleared by writing zero.
`timescale 1ns/1ps

module ucr_flags #(
  parameter int W = 9
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] set_evt,
  input wire logic clr_wr,
  input wire logic [W-1:0] clr_data,
  output logic [W-1:0] flags_ff
);

  // ==========================================================================
  // Next value
  // ==========================================================================
  // A set in the same cycle as a clear wins, so no event is lost.
  wire [W-1:0] keep_mask = clr_wr ? clr_data : {W{1'b1}};
  wire [W-1:0] nxt_flags = (flags_ff & keep_mask) | set_evt;

  // ==========================================================================
  // Storage
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

endmodule // ucr_flags

// file: logic/ucr_top.sv
// Common control registers, status flags and packet memory of the USB block.
// ============================================================================
// Notes on behaviour
// - Registers decode as offsets from base.
// - 16-bit registers, one aligned word each.
// - Packet memory uses same word-aligned addressing.
// - Descriptor table sits at programmed base.
// - Writing zero clears flag, one keeps.
// - Writing one toggles bit, zero keeps.
// - Read-only bits ignore software writes.
// - Control at 840h, resets to 0003h.
// - Bit 15 masks transfer-done interrupt.
// - Bit 14 masks DMA overflow interrupt.
// - Bit 13 masks fault interrupt.
// - Bit 12 masks wake interrupt.
// - Bit 11 masks sleep-request interrupt.
// - Bit 10 masks bus-reinit interrupt.
// ============================================================================
`timescale 1ns/1ps

module ucr_top #(
  parameter int PKT_WORDS = 256,
  parameter int PKT_IDX_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ucr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ucr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ucr_pkg::DATA_W-1:0] reg_rdata_ff,
  input wire ucr_pkg::ucr_evt_t evt,
  input wire logic [ucr_pkg::EPID_W-1:0] ep_id,
  input wire logic hw_toggle,
  input wire ucr_pkg::ucr_desc_req_t desc_req,
  output logic [ucr_pkg::REG_W-1:0] desc_data_ff,
  output logic desc_valid_ff,
  output ucr_pkg::ucr_ctl_t ctl_ff,
  output logic irq_ff
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Exact word match; a byte address with low bits set maps nowhere.
  function automatic logic hit_word(
    input logic [ucr_pkg::ADDR_W-1:0] addr,
    input logic [ucr_pkg::ADDR_W-1:0] ofs
  );
    hit_word = (addr == ofs);
  endfunction

  // Packet memory is addressed in bytes of 16-bit words from the engine side.
  function automatic logic [PKT_IDX_W-1:0] pkt_index_of(
    input logic [15:0] byte_addr
  );
    pkt_index_of = byte_addr[PKT_IDX_W:1];
  endfunction

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [15:0] dev_ctl_ff;
  logic [15:0] ep_ctl_ff;
  logic [15:0] desc_base_ff;
  logic [ucr_pkg::EPID_W-1:0] ep_id_ff;
  logic [ucr_pkg::FLAG_N-1:0] flags_ff;
  logic [15:0] pkt_mem [PKT_WORDS];

  // ==========================================================================
  // Address decode
  // ==========================================================================
  wire hit_dev_ctl =
    hit_word(reg_addr, ucr_pkg::OFS_DEV_CTL);
  wire hit_stat = hit_word(reg_addr, ucr_pkg::OFS_IRQ_STAT);
  wire hit_desc = hit_word(reg_addr, ucr_pkg::OFS_DESC_BASE);
  wire hit_ep = hit_word(reg_addr, ucr_pkg::OFS_EP_CTL);
  wire [12:0] pkt_rel = {1'b0, reg_addr} - {1'b0, ucr_pkg::OFS_PKT_MEM};
  wire pkt_aligned = (reg_addr[1:0] == 2'b00);
  wire pkt_in_range = !pkt_rel[12] &&
                      (pkt_rel < 13'(PKT_WORDS * 4));
  wire hit_pkt = pkt_aligned && pkt_in_range;
  wire [PKT_IDX_W-1:0] pkt_sw_idx =
    pkt_rel[PKT_IDX_W+ucr_pkg::PKT_WORD_SHIFT-1:ucr_pkg::PKT_WORD_SHIFT];

  wire wr_dev_ctl = reg_wr && hit_dev_ctl;
  wire wr_stat = reg_wr && hit_stat;
  wire wr_desc = reg_wr && hit_desc;
  wire wr_ep = reg_wr && hit_ep;
  wire wr_pkt = reg_wr && hit_pkt;
  wire [15:0] wdata16 = reg_wdata[15:0];

  // ==========================================================================
  // Control register
  // ==========================================================================
  // Reserved bits 6 and 5 are dropped on write and so always read zero.
  wire [15:0] nxt_dev_ctl = wr_dev_ctl ?
    (wdata16 & ucr_pkg::DEV_CTL_RW_MASK) : dev_ctl_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dev_ctl_ff <= ucr_pkg::RST_DEV_CTL;
    end else begin
      dev_ctl_ff <= nxt_dev_ctl;
    end
  end

  // The control outputs follow the register bits from the same edge.
  wire [4:0] nxt_ctl = {nxt_dev_ctl[ucr_pkg::CTL_RESUME],
                        nxt_dev_ctl[ucr_pkg::CTL_FSLEEP],
                        nxt_dev_ctl[ucr_pkg::CTL_LOWPWR],
                        nxt_dev_ctl[ucr_pkg::CTL_PDOWN],
                        nxt_dev_ctl[ucr_pkg::CTL_FREINIT]};
  // A constant, so the asynchronous reset branch loads no logic value.
  localparam logic [4:0] RST_CTL = {ucr_pkg::RST_DEV_CTL[ucr_pkg::CTL_RESUME],
                        ucr_pkg::RST_DEV_CTL[ucr_pkg::CTL_FSLEEP],
                        ucr_pkg::RST_DEV_CTL[ucr_pkg::CTL_LOWPWR],
                        ucr_pkg::RST_DEV_CTL[ucr_pkg::CTL_PDOWN],
                        ucr_pkg::RST_DEV_CTL[ucr_pkg::CTL_FREINIT]};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_ff <= ucr_pkg::ucr_ctl_t'(RST_CTL);
    end else begin
      ctl_ff <= ucr_pkg::ucr_ctl_t'(nxt_ctl);
    end
  end

  // ==========================================================================
  // Interrupt status flags
  // ==========================================================================
  ucr_flags #(
    .W(ucr_pkg::FLAG_N)
  ) u_flags (
    .clk_sys(clk_sys),
    .rst(rst),
    .set_evt(evt),
    .clr_wr(wr_stat),
    .clr_data(wdata16[15:ucr_pkg::FLAG_LSB]),
    .flags_ff(flags_ff)
  );

  // The endpoint number is a read-only field; software writes never reach it.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ep_id_ff <= '0;
    end else begin
      ep_id_ff <= ep_id;
    end
  end

  // ==========================================================================
  // Interrupt request
  // ==========================================================================
  wire [ucr_pkg::FLAG_N-1:0] irq_mask = dev_ctl_ff[15:ucr_pkg::FLAG_LSB];
  wire src_done = flags_ff[8] && irq_mask[8];
  wire src_dma = flags_ff[7] && irq_mask[7];
  wire src_fault = flags_ff[6] && irq_mask[6];
  wire src_wake = flags_ff[5] && irq_mask[5];
  wire src_sleep = flags_ff[4] && irq_mask[4];
  wire src_reinit = flags_ff[3] && irq_mask[3];
  wire src_rest = |(flags_ff[2:0] & irq_mask[2:0]);
  wire nxt_irq = src_done | src_dma | src_fault | src_wake |
                 src_sleep | src_reinit | src_rest;

  // Registered, so the request lags its flag or mask by one cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // ==========================================================================
  // Endpoint control with toggle bits
  // ==========================================================================
  wire [15:0] ep_plain = wr_ep ?
    ((ep_ctl_ff & ucr_pkg::EP_TOGGLE_MASK) |
     (wdata16 & ~ucr_pkg::EP_TOGGLE_MASK)) : ep_ctl_ff;
  wire [15:0] sw_flip = wr_ep ?
    (wdata16 & ucr_pkg::EP_TOGGLE_MASK) : 16'h0000;
  wire [15:0] hw_flip = hw_toggle ?
    (16'h0001 << ucr_pkg::EP_HW_TOGGLE_BIT) : 16'h0000;
  // Software and hardware flips in one cycle both apply.
  wire [15:0] nxt_ep_ctl = ep_plain ^ sw_flip ^ hw_flip;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ep_ctl_ff <= ucr_pkg::RST_EP_CTL;
    end else begin
      ep_ctl_ff <= nxt_ep_ctl;
    end
  end

  // ==========================================================================
  // Descriptor table base
  // ==========================================================================
  // Entries are eight bytes, so the low three bits are held at zero.
  wire [15:0] nxt_desc_base = wr_desc ?
    (wdata16 & ucr_pkg::DESC_BASE_MASK) : desc_base_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      desc_base_ff <= ucr_pkg::RST_DESC_BASE;
    end else begin
      desc_base_ff <= nxt_desc_base;
    end
  end

  // ==========================================================================
  // Packet memory
  // ==========================================================================
  // Memory content has no reset; software must fill it before use.
  always_ff @(posedge clk_sys) begin
    if (wr_pkt) begin
      pkt_mem[pkt_sw_idx] <= wdata16;
    end
  end

  // Engine lookup: entry address is base plus index and field offsets.
  wire [15:0] desc_byte = desc_base_ff +
    (16'(desc_req.idx) << ucr_pkg::DESC_IDX_SHIFT) +
    (16'(desc_req.sel) << ucr_pkg::DESC_SEL_SHIFT);
  wire [PKT_IDX_W-1:0] desc_idx = pkt_index_of(desc_byte);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      desc_data_ff <= ucr_pkg::RST_REG16;
      desc_valid_ff <= 1'b0;
    end else begin
      desc_valid_ff <= desc_req.rd;
      desc_data_ff <= desc_req.rd ? pkt_mem[desc_idx] : ucr_pkg::RST_REG16;
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  wire [15:0] stat_view = {flags_ff, 3'b000, ep_id_ff};
  wire [15:0] rd_mux = hit_dev_ctl ? dev_ctl_ff :
                       hit_stat ? stat_view :
                       hit_desc ? desc_base_ff :
                       hit_ep ? ep_ctl_ff :
                       hit_pkt ? pkt_mem[pkt_sw_idx] :
                       ucr_pkg::RST_REG16;
  // Unmapped addresses read zero, and the upper half is always zero.
  wire [31:0] nxt_rdata = reg_rd ?
    {ucr_pkg::UPPER_ZERO, rd_mux} : ucr_pkg::RST_RDATA;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= ucr_pkg::RST_RDATA;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule // ucr_top

// file: sim/ucr_top_chk.sv
// Port checks for the USB control register block.
`timescale 1ns/1ps

module ucr_chk #(
  parameter int PKT_WORDS = 256,
  parameter int PKT_IDX_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ucr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ucr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ucr_pkg::DATA_W-1:0] reg_rdata_ff,
  input wire ucr_pkg::ucr_evt_t evt,
  input wire logic [ucr_pkg::EPID_W-1:0] ep_id,
  input wire ucr_pkg::ucr_desc_req_t desc_req,
  input wire logic [ucr_pkg::REG_W-1:0] desc_data_ff,
  input wire logic desc_valid_ff,
  input wire ucr_pkg::ucr_ctl_t ctl_ff,
  input wire logic irq_ff
);
  // ==========================================================================
  // Decode
  // ==========================================================================
  wire logic ctl_wr = reg_wr && reg_addr == ucr_pkg::OFS_DEV_CTL;
  wire logic ctl_rd = reg_rd && reg_addr == ucr_pkg::OFS_DEV_CTL;
  wire logic stat_rd = reg_rd && reg_addr == ucr_pkg::OFS_IRQ_STAT;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata_ff == 32'h0000_0000)
    else $error("read data not zero outside read cycle");
  upper_zero_a: assert property (
    reg_rdata_ff[31:16] == 16'h0000)
    else $error("upper half of read word not zero");
  ctl_read_a: assert property (
    ctl_rd |=> reg_rdata_ff[6:0] == {2'b00, ctl_ff})
    else $error("control read disagrees with control outputs");
  ctl_write_a: assert property (
    ctl_wr |=> ctl_ff == $past(reg_wdata[4:0]))
    else $error("control outputs did not take written value");
  ctl_hold_a: assert property (
    !ctl_wr |=> $stable(ctl_ff))
    else $error("control outputs changed without a write");
  unmapped_read_a: assert property (
    reg_rd && reg_addr == 12'h900 |=> reg_rdata_ff == 32'h0000_0000)
    else $error("unmapped read returned data");
  stat_ro_a: assert property (
    stat_rd |=> reg_rdata_ff[6:0] == {3'b000, $past(ep_id, 2)})
    else $error("status low field wrong");
  irq_rise_a: assert property (
    $rose(irq_ff) |-> $past(evt != '0, 2) || $past(ctl_wr, 2))
    else $error("interrupt rose without event or mask write");
  irq_fall_a: assert property (
    $fell(irq_ff) |-> $past(reg_wr, 2))
    else $error("interrupt fell without a write");
  desc_idle_a: assert property (
    !desc_req.rd |=> !desc_valid_ff && desc_data_ff == 16'h0000)
    else $error("descriptor output active without request");
  desc_ans_a: assert property (
    desc_req.rd |=> desc_valid_ff)
    else $error("descriptor answer missing");
endmodule // ucr_chk

bind ucr_top ucr_chk #(.PKT_WORDS(PKT_WORDS), .PKT_IDX_W(PKT_IDX_W)) i_chk (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .evt(evt),
  .ep_id(ep_id), .desc_req(desc_req), .desc_data_ff(desc_data_ff),
  .desc_valid_ff(desc_valid_ff), .ctl_ff(ctl_ff), .irq_ff(irq_ff));

// file: sim/tb_ucr_top.sv
// Self-checking bench for the USB control register block.
`timescale 1ns/1ps

module tb_ucr_top;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } ucr_row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata_ff;
  ucr_pkg::ucr_evt_t evt = '0;
  logic [3:0] ep_id = 4'h5;
  logic hw_toggle = 1'b0;
  ucr_pkg::ucr_desc_req_t desc_req = '0;
  logic [15:0] desc_data_ff;
  logic desc_valid_ff;
  ucr_pkg::ucr_ctl_t ctl_ff;
  logic irq_ff;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] d;
  // Write, read back, compare; misaligned and unmapped places read zero.
  ucr_row_t rows [8] = '{
    '{12'h840, 32'hffff_ffff, 32'h0000_ff9f},
    '{12'h840, 32'h0000_0000, 32'h0000_0000},
    '{12'h850, 32'h0000_ffff, 32'h0000_fff8},
    '{12'h404, 32'h0000_a5a5, 32'h0000_a5a5},
    '{12'h7fc, 32'h0000_1234, 32'h0000_1234},
    '{12'h842, 32'h0000_ffff, 32'h0000_0000},
    '{12'h900, 32'h0000_ffff, 32'h0000_0000},
    '{12'h000, 32'h0000_0fff, 32'h0000_0fff}};

  ucr_top #(.PKT_WORDS(256), .PKT_IDX_W(8)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .evt(evt), .ep_id(ep_id),
    .hw_toggle(hw_toggle), .desc_req(desc_req),
    .desc_data_ff(desc_data_ff), .desc_valid_ff(desc_valid_ff),
    .ctl_ff(ctl_ff), .irq_ff(irq_ff));

  always #25 clk_sys = ~clk_sys;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] w);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // A hang ends the run as a mismatch.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    check(32'(ctl_ff), 32'h0000_0003);
    rd(12'h840);
    check(d, 32'h0000_0003);
    rd(12'h844);
    check(d, 32'h0000_0005);
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].w);
      rd(rows[k].a);
      check(d, rows[k].e);
    end
    $display("register table test done");
    wr(12'h000, 32'h0000_f000);
    rd(12'h000);
    check(d, 32'h0000_f000);
    wr(12'h000, 32'h0000_5000);
    rd(12'h000);
    check(d, 32'h0000_a000);
    @(posedge clk_sys);
    hw_toggle <= 1'b1;
    @(posedge clk_sys);
    hw_toggle <= 1'b0;
    rd(12'h000);
    check(d, 32'h0000_b000);
    $display("toggle test done");
    for (int i = 7; i < 16; i++) begin
      @(posedge clk_sys);
      evt <= ucr_pkg::ucr_evt_t'(9'h001 << (i - 7));
      @(posedge clk_sys);
      evt <= '0;
      repeat (3) @(posedge clk_sys);
      #1 check(32'(irq_ff), 32'h0000_0000);
      wr(12'h844, 32'h0000_ffff);
      rd(12'h844);
      check(d, (32'h1 << i) | 32'h5);
      wr(12'h840, 32'h1 << i);
      repeat (2) @(posedge clk_sys);
      #1 check(32'(irq_ff), 32'h0000_0001);
      wr(12'h844, ~(32'h1 << i));
      repeat (2) @(posedge clk_sys);
      #1 check(32'(irq_ff), 32'h0000_0000);
      wr(12'h840, 32'h0000_0000);
    end
    $display("flag and mask test done");
    // An event in the same cycle as a clearing write must survive it.
    @(posedge clk_sys);
    evt <= ucr_pkg::ucr_evt_t'(9'h100);
    reg_wr <= 1'b1;
    reg_addr <= 12'h844;
    reg_wdata <= 32'h0000_0000;
    @(posedge clk_sys);
    evt <= '0;
    reg_wr <= 1'b0;
    rd(12'h844);
    check(d, 32'h0000_8005);
    $display("set wins test done");
    wr(12'h850, 32'h0000_0010);
    wr(12'h438, 32'h0000_beef);
    @(posedge clk_sys);
    desc_req <= ucr_pkg::ucr_desc_req_t'{1'b1, 4'h1, 2'h2};
    @(posedge clk_sys);
    desc_req <= '0;
    #1 check({15'h0, desc_valid_ff, desc_data_ff}, 32'h0001_beef);
    $display("descriptor test done");
    // A second reset in mid-run must bring back the documented values.
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(12'h840);
    check(d, 32'h0000_0003);
    rd(12'h850);
    check(d, 32'h0000_0000);
    $display("second reset test done");
    conclude();
  end
endmodule // tb_ucr_top
